// File: common/dprx_pkg.sv
// Package with constants and types for the DPSK receive descrambler and test logic.
package dprx_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ       = 125_000_000;
  localparam int RATE_HI_BPS  = 2400;
  localparam int RATE_LO_BPS  = 1200;
  localparam int DIBIT_HZ     = 1200;
  localparam int CNT_W        = 17;

  // ----------------------------------------
  // Pattern register
  // ----------------------------------------
  localparam int PN_LEN  = 9;
  localparam int PN_TAPA = 4;
  localparam int PN_TAPB = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_ERRCNT = 8'h08;
  localparam int          CTL_DESC   = 0;
  localparam int          CTL_RATE   = 1;
  localparam int          CTL_MONSEL = 2;
  localparam int          CTL_PHASE  = 3;
  localparam int          CTL_TOGGLE = 4;
  localparam int          CTL_W      = 5;
  localparam logic [4:0]  CTRL_RST   = 5'h06;
  localparam int          ERR_W      = 16;
  localparam logic [15:0] ERR_MAX    = 16'hFFFF;

  // Internal points from the filter and converter section.
  typedef struct packed {
    logic eye0_6tap;
    logic eye0_12tap;
    logic eye90_12tap;
    logic zero_cross;
    logic carrier0;
    logic corr_enable;
    logic corr_direction;
    logic strobe_normal;
    logic clock_normal;
  } dprx_mon_t;

endpackage

// File: rtl/dprx_descrambler.sv
// Self-synchronous descrambler built on the nine-stage pattern register.
`timescale 1ns/10ps
module dprx_descrambler
  import dprx_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic bit_en_in,
  input  wire logic data_in,
  output logic      desc_out
);

  logic [PN_LEN-1:0] stages;

  // The register holds received line bits, so it locks after nine bits.
  assign desc_out = data_in ^ stages[PN_TAPA] ^ stages[PN_TAPB];

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stages <= '0;
    end else if (bit_en_in) begin
      stages <= {stages[PN_LEN-2:0], data_in};
    end
  end

  chk_desc_shift: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    bit_en_in |=> stages[0] == $past(data_in) && stages[PN_TAPB] == $past(stages[PN_TAPB-1]))
    else $error("Pattern register did not shift the received bit.");

endmodule

// File: rtl/dprx_top.sv
// Receive bit timing, descrambler control, test monitor routing and APB registers.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
module dprx_top
  import dprx_pkg::*;
#(
  parameter int BIT_DIV_HI = CLK_HZ / RATE_HI_BPS,
  parameter int BIT_DIV_LO = CLK_HZ / RATE_LO_BPS,
  parameter int DIBIT_DIV  = CLK_HZ / DIBIT_HZ
)(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        rx_line_data_in,
  input  wire logic        envelope_in,
  input  wire dprx_mon_t   mon_in,
  output logic             rx_data_out,
  output logic             rx_clock_out,
  output logic             dibit_timing_clock_out,
  output logic             converter_strobe_out,
  output logic             converter_clock_out,
  output logic             eye0_out,
  output logic             eye90_out,
  output logic             carrier0_out,
  output logic             carrier_correction_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] sync_c;
  logic [1:0] pin_f;

  assign pin_raw = {envelope_in, rx_line_data_in};

  // A change counts only when two late stages agree, which rejects a lone glitch.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
        sync_c[i] <= 1'b0;
        pin_f[i]  <= 1'b0;
      end else begin
        sync_a[i] <= pin_raw[i];
        sync_b[i] <= sync_a[i];
        sync_c[i] <= sync_b[i];
        if (sync_b[i] == sync_c[i]) begin
          pin_f[i] <= sync_c[i];
        end
      end
    end
  end

  logic line_bit;
  logic env_lvl;
  logic line_q;
  logic env_q;

  assign line_bit = pin_f[0];
  assign env_lvl  = pin_f[1];

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  logic [CTL_W-1:0] ctrl;
  logic             desc_en;
  logic             rate_hi;
  logic             tmon;
  logic             phase_static;
  logic             phase_toggle;

  assign desc_en      = ctrl[CTL_DESC];
  assign rate_hi      = ctrl[CTL_RATE];
  assign tmon         = !ctrl[CTL_MONSEL];
  assign phase_static = ctrl[CTL_PHASE];
  assign phase_toggle = ctrl[CTL_TOGGLE];

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;
  logic [CNT_W-1:0] bit_last;
  logic [CNT_W-1:0] bit_half;
  logic             bit_wrap;
  logic             sample_en;
  logic             data_edge;
  logic             hold_cnt;
  logic             skip_cnt;

  assign bit_last  = rate_hi ? CNT_W'(BIT_DIV_HI - 1) : CNT_W'(BIT_DIV_LO - 1);
  assign bit_half  = bit_last >> 1;
  assign bit_wrap  = bit_cnt >= bit_last;
  assign sample_en = bit_cnt == bit_half;
  assign data_edge = line_bit != line_q;

  // Transitions belong on the boundary: a late one stretches the bit, an early one shortens it.
  // Monitor mode freezes this tracking, which is the timing change it brings.
  assign hold_cnt = data_edge && !tmon && bit_cnt != '0 && bit_cnt < bit_half;
  assign skip_cnt = data_edge && !tmon && bit_cnt > bit_half
                    && bit_cnt < bit_last - CNT_W'(1);

  assign next_bit_cnt = bit_wrap ? '0 :
                        hold_cnt ? bit_cnt :
                        skip_cnt ? bit_cnt + CNT_W'(2) :
                        bit_cnt + CNT_W'(1);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt <= '0;
      line_q  <= 1'b0;
      env_q   <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      line_q  <= line_bit;
      env_q   <= env_lvl;
    end
  end

  // Rising edge at the bit centre normally, falling edge there when descrambling.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_clock_out <= 1'b0;
    end else begin
      rx_clock_out <= (bit_cnt >= bit_half) ^ desc_en;
    end
  end

  // ----------------------------------------
  // Dibit timing clock
  // ----------------------------------------
  logic [CNT_W-1:0] dibit_cnt;
  logic [CNT_W-1:0] dibit_last;
  logic             env_rise;

  assign dibit_last = CNT_W'(DIBIT_DIV - 1);
  assign env_rise   = env_lvl && !env_q;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dibit_cnt              <= '0;
      dibit_timing_clock_out <= 1'b0;
    end else begin
      if (env_rise || dibit_cnt >= dibit_last) begin
        dibit_cnt <= '0;
      end else begin
        dibit_cnt <= dibit_cnt + CNT_W'(1);
      end
      dibit_timing_clock_out <= dibit_cnt < (dibit_last >> 1);
    end
  end

  // ----------------------------------------
  // Descrambler and data path
  // ----------------------------------------
  logic desc_bit;
  logic held_bit;
  logic pattern_bit;
  logic cmp_err;
  logic eff_phase;

  dprx_descrambler u_desc (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .bit_en_in (sample_en),
    .data_in   (line_bit),
    .desc_out  (desc_bit)
  );

  // A clean pattern descrambles to zero; its complement gives the steady mark, and
  // setting the phase toggle option turns that into a steady space.
  assign pattern_bit = !desc_bit ^ phase_toggle;
  assign cmp_err     = sample_en && desc_en && desc_bit;
  assign eff_phase   = phase_static ^ (phase_toggle & dibit_timing_clock_out);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_bit    <= 1'b1;
      rx_data_out <= 1'b1;
    end else begin
      if (sample_en) begin
        held_bit <= desc_en ? pattern_bit : line_bit;
      end
      if (bit_wrap) begin
        rx_data_out <= held_bit;
      end
    end
  end

  // ----------------------------------------
  // Check accumulator
  // ----------------------------------------
  logic [ERR_W-1:0] err_cnt;
  logic             err_clr;

  // A count arriving with a clear is kept, unless the count sits at ERR_MAX, where the clear leaves zero.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_cnt <= '0;
    end else if (cmp_err && err_cnt != ERR_MAX) begin
      err_cnt <= err_clr ? ERR_W'(1) : err_cnt + ERR_W'(1);
    end else if (err_clr) begin
      err_cnt <= '0;
    end
  end

  // ----------------------------------------
  // Internal monitor routing
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      converter_strobe_out   <= 1'b0;
      converter_clock_out    <= 1'b0;
      eye0_out               <= 1'b0;
      eye90_out              <= 1'b0;
      carrier0_out           <= 1'b0;
      carrier_correction_out <= 1'b0;
    end else begin
      converter_strobe_out   <= tmon ? mon_in.zero_cross : mon_in.strobe_normal;
      converter_clock_out    <= tmon ? err_cnt[0] : mon_in.clock_normal;
      eye0_out               <= tmon ? mon_in.eye0_12tap : mon_in.eye0_6tap;
      eye90_out              <= mon_in.eye90_12tap;
      carrier0_out           <= tmon ? cmp_err : mon_in.carrier0;
      carrier_correction_out <= tmon ? mon_in.corr_direction : mon_in.corr_enable;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_err;
  logic        hit_any;
  logic        acc_wr;
  logic        setup_rd;
  logic [31:0] rd_mux;

  assign hit_ctrl = paddr_in == OFS_CTRL;
  assign hit_stat = paddr_in == OFS_STATUS;
  assign hit_err  = paddr_in == OFS_ERRCNT;
  assign hit_any  = hit_ctrl || hit_stat || hit_err;
  assign acc_wr   = psel_in && penable_in && pwrite_in && hit_any;
  assign setup_rd = psel_in && !penable_in && !pwrite_in;
  assign err_clr  = acc_wr && hit_err;

  assign rd_mux = hit_ctrl ? {27'h0000000, ctrl} :
                  hit_stat ? {27'h0000000, tmon, eff_phase, rx_clock_out,
                              dibit_timing_clock_out, rx_data_out} :
                  hit_err  ? {16'h0000, err_cnt} : 32'h00000000;

  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit_any;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl       <= CTRL_RST;
      prdata_out <= '0;
    end else begin
      if (acc_wr && hit_ctrl) begin
        ctrl <= pwdata_in[CTL_W-1:0];
      end
      if (setup_rd) begin
        prdata_out <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_desc_bypass: assert property (sample_en && !desc_en |=> held_bit == $past(line_bit))
    else $error("Bypassed data was altered.");

  chk_pattern_mark: assert property (
    sample_en && desc_en && !desc_bit && !phase_toggle |=> held_bit)
    else $error("Clean pattern with static phase did not give a one.");

  chk_pattern_space: assert property (
    sample_en && desc_en && !desc_bit && phase_toggle |=> !held_bit)
    else $error("Clean pattern with toggled phase did not give a zero.");

  // A rate change may leave the counter above the new divisor for the one cycle before it wraps.
  chk_bit_period: assert property ($changed(rate_hi) || bit_cnt <= bit_last)
    else $error("Bit counter ran past the divisor.");

  chk_clk_centre: assert property (
    sample_en && !hold_cnt ##1 !$changed(ctrl) |=> rx_clock_out != desc_en)
    else $error("Bit clock edge at centre has the wrong direction.");

  chk_track_freeze: assert property (
    tmon && !bit_wrap |=> bit_cnt == $past(bit_cnt) + CNT_W'(1))
    else $error("Timing tracking moved in monitor mode.");

  chk_track_late: assert property (
    hold_cnt && !$changed(ctrl) |=> bit_cnt == $past(bit_cnt))
    else $error("Late transition did not stretch the bit.");

  chk_strobe_route: assert property (
    ##1 converter_strobe_out == $past(tmon ? mon_in.zero_cross : mon_in.strobe_normal))
    else $error("Converter strobe shows the wrong source.");

  chk_eye_route: assert property (
    ##1 eye0_out == $past(tmon ? mon_in.eye0_12tap : mon_in.eye0_6tap)
    && eye90_out == $past(mon_in.eye90_12tap))
    else $error("Eye output shows the wrong filter.");

  chk_car_route: assert property (
    ##1 carrier0_out == $past(tmon ? cmp_err : mon_in.carrier0))
    else $error("Carrier output shows the wrong source.");

  chk_carrier_correction_out_route: assert property (
    ##1 carrier_correction_out == $past(tmon ? mon_in.corr_direction : mon_in.corr_enable))
    else $error("Correction output shows the wrong source.");

  chk_dibit_phase: assert property (env_rise |=> ##1 dibit_timing_clock_out)
    else $error("Dibit clock not realigned to the envelope.");

  cov_pattern_err: cover property (cmp_err ##1 err_cnt != '0);
  cov_monitor:     cover property (tmon && mon_in.zero_cross);
  cov_realign:     cover property (env_rise && dibit_cnt > (dibit_last >> 1));
  cov_late_edge:   cover property (hold_cnt);

endmodule

// File: verification/dprx_line_model.sv
// Line-side source model: sends a level or the scrambled test pattern plus the data envelope.
`timescale 1ns/10ps
module dprx_line_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       pattern_in,
  input  wire logic       level_in,
  input  wire logic [7:0] bit_div_in,
  output logic            line_out,
  output logic            envelope_out
);
  // ----------------------------------------
  // Pattern generator and bit timing
  // ----------------------------------------
  logic [8:0] pn;
  logic [7:0] cnt;
  logic [7:0] ecnt;
  wire        fb = pn[4] ^ pn[8];

  // Transmit data is all zeros, so the line carries the bare sequence after the one-bit delay.
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pn           <= 9'h1FF;
      cnt          <= 8'h00;
      ecnt         <= 8'h00;
      line_out     <= 1'b1;
      envelope_out <= 1'b0;
    end else begin
      ecnt         <= (ecnt == 8'h4F) ? 8'h00 : ecnt + 8'h01;
      envelope_out <= (ecnt < 8'h28);
      if (cnt >= bit_div_in - 8'h01) begin
        cnt      <= 8'h00;
        pn       <= {pn[7:0], fb};
        line_out <= pattern_in ? (1'b0 ^ fb) : level_in;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule

// File: verification/dprx_top_bench.sv
// Self-checking bench for the receive descrambler, bit timing, monitor routing and registers.
`timescale 1ns/10ps
module dprx_top_bench;
  import dprx_pkg::*;
  localparam int DHI = 40;
  localparam int DLO = 80;
  logic             clock_in = 1'b0;
  logic             rst_n_in = 1'b0;
  logic             psel_in = 1'b0;
  logic             penable_in = 1'b0;
  logic             pwrite_in = 1'b0;
  logic [7:0]       paddr_in = 8'h00;
  logic [31:0]      pwdata_in = 32'h0;
  dprx_mon_t        mon_in = '0;
  logic [31:0]      prdata_out;
  logic             pready_out, pslverr_out, rx_line_data_in, envelope_in;
  logic             rx_data_out, rx_clock_out, dibit_timing_clock_out;
  logic             converter_strobe_out, converter_clock_out, eye0_out, eye90_out;
  logic             carrier0_out, carrier_correction_out;
  logic             pattern_on = 1'b0, line_level = 1'b1, desc_en = 1'b0;
  logic [7:0]       bit_div = 8'h28;
  int               errors = 0, samples_checked = 0, cycles = 0, n, i, m;
  logic [31:0]      r;
  logic [32:0]      expq[$];
  logic [2:0]       watch;
  // The enable here is active high, so the terminal's exclusive-NOR becomes an exclusive-OR.
  wire              term_clock = desc_en ^ rx_clock_out;
  assign watch = {term_clock, dibit_timing_clock_out, rx_clock_out};

  always #4 clock_in = ~clock_in;

  dprx_top #(.BIT_DIV_HI(DHI), .BIT_DIV_LO(DLO), .DIBIT_DIV(80)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .rx_line_data_in(rx_line_data_in), .envelope_in(envelope_in), .mon_in(mon_in),
    .rx_data_out(rx_data_out), .rx_clock_out(rx_clock_out),
    .dibit_timing_clock_out(dibit_timing_clock_out),
    .converter_strobe_out(converter_strobe_out), .converter_clock_out(converter_clock_out),
    .eye0_out(eye0_out), .eye90_out(eye90_out), .carrier0_out(carrier0_out),
    .carrier_correction_out(carrier_correction_out));

  // Production test clock and strobe are not brought out, which is the same as leaving them open.

  // Far-side eye observer: shifts both eye bits on the converter clock, latches on the strobe.
  logic [1:0] conv_q = 2'h0;
  logic [7:0] eye_shift = 8'h00;
  logic [7:0] eye_sample = 8'h00;
  always @(posedge clock_in) begin
    conv_q <= {converter_strobe_out, converter_clock_out};
    if (converter_clock_out && !conv_q[0]) begin
      eye_shift <= {eye_shift[5:0], eye0_out, eye90_out};
    end
    if (converter_strobe_out && !conv_q[1]) begin
      eye_sample <= eye_shift;
    end
  end

  dprx_line_model line (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .pattern_in(pattern_on), .level_in(line_level),
    .bit_div_in(bit_div), .line_out(rx_line_data_in), .envelope_out(envelope_in));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task cmp33(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp1(input logic got, input logic exp);
    cmp33({32'h0, got}, {32'h0, exp});
  endtask

  task cmpn(input int got, input int exp);
    cmp33({1'b0, got}, {1'b0, exp});
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang in any wait ends the run here.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end

  // Read results are checked where the access completes, against the oldest note.
  always @(posedge clock_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
      cmp33({pslverr_out, prdata_out}, expq.pop_front());
    end
  end

  // ----------------------------------------
  // Bus and timing helpers
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) expq.push_back(e);
    @(posedge clock_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1) @(posedge clock_in);
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Counts cycles between two rising edges of the watched clock, bounded.
  task per(input int sel, output int cnt);
    logic p;
    for (int k = 0; k < 2; k++) begin
      cnt = 0;
      do begin
        p = watch[sel];
        @(posedge clock_in);
        #1;
        cnt++;
      end while (!(watch[sel] === 1'b1 && p === 1'b0) && cnt < 500);
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    r = $urandom(32'h80d3);
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h6});
    apb(1'b0, 8'h08, 32'h0, 33'h0);
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    r = $urandom;
    apb(1'b1, 8'h00, r, 33'h0);
    apb(1'b0, 8'h00, 32'h0, {1'b0, 27'h0, r[4:0]});
    apb(1'b1, 8'h00, 32'h6, 33'h0);
    $display("test registers done");
    for (m = 0; m < 2; m++) begin
      apb(1'b1, 8'h00, m ? 32'h6 : 32'h2, 33'h0);
      // The random control write may have counted errors; the accumulator must start at zero.
      apb(1'b1, 8'h08, 32'h0, 33'h0);
      for (i = 0; i < 8; i++) begin
        r = $urandom;
        @(posedge clock_in);
        mon_in <= r[8:0];
        repeat (3) @(posedge clock_in);
        #1;
        cmp1(eye90_out, mon_in.eye90_12tap);
        cmp1(eye0_out, m ? mon_in.eye0_6tap : mon_in.eye0_12tap);
        cmp1(carrier_correction_out, m ? mon_in.corr_enable : mon_in.corr_direction);
        cmp1(converter_strobe_out, m ? mon_in.strobe_normal : mon_in.zero_cross);
        cmp1(converter_clock_out, m ? mon_in.clock_normal : 1'b0);
        cmp1(carrier0_out, m ? mon_in.carrier0 : 1'b0);
      end
    end
    $display("test monitor done");
    for (m = 1; m >= 0; m--) begin
      apb(1'b1, 8'h00, m ? 32'h6 : 32'h4, 33'h0);
      bit_div <= m ? 8'h28 : 8'h50;
      per(0, n);
      cmpn(n, m ? DHI : DLO);
      per(1, n);
      cmpn(n, 80);
    end
    $display("test rates done");
    for (m = 0; m < 2; m++) begin
      line_level <= m[0];
      repeat (4 * DHI) @(posedge clock_in);
      per(2, n);
      cmp1(rx_data_out, m[0]);
    end
    $display("test passthrough done");
    // The source must send at the 2400 rate that the control writes below select.
    pattern_on <= 1'b1;
    desc_en    <= 1'b1;
    bit_div    <= 8'h28;
    for (m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'h7 | (m[0] ? 32'h8 : 32'h0) | (m[1] ? 32'h10 : 32'h0), 33'h0);
      repeat (50 * DHI) @(posedge clock_in);
      apb(1'b1, 8'h08, 32'h0, 33'h0);
      for (i = 0; i < 12; i++) begin
        per(2, n);
        cmp1(rx_data_out, !m[1]);
      end
      apb(1'b0, 8'h08, 32'h0, 33'h0);
    end
    $display("test descrambler done");
    stop_test();
  end
endmodule
